// ### src/sscs_pkg.sv
// Purpose: Constants and carrier types for the striped SSD command and status registers.
// Assumes: 32-bit register port with byte addresses, one clock, asynchronous reset.
// Notes: Memory regions are word arrays indexed by channel and word.
package sscs_pkg;
   // ***************************************************************
   // Register byte addresses
   // ***************************************************************
   localparam logic [16:0] ADDR_START_LO = 17'h00000;
   localparam logic [16:0] ADDR_START_HI = 17'h00004;
   localparam logic [16:0] ADDR_LEN_LO = 17'h00008;
   localparam logic [16:0] ADDR_LEN_HI = 17'h0000C;
   localparam logic [16:0] ADDR_COMMAND = 17'h00010;
   localparam logic [16:0] ADDR_PATTERN = 17'h00014;
   localparam logic [16:0] ADDR_STATUS = 17'h00100;
   localparam logic [16:0] ADDR_CAP_LO = 17'h00104;
   localparam logic [16:0] ADDR_CAP_HI = 17'h00108;
   localparam logic [16:0] ADDR_ERR_CH0 = 17'h00110;
   localparam logic [16:0] ADDR_ERR_CH1 = 17'h00114;
   localparam logic [16:0] ADDR_SUBM_BASE = 17'h00400;
   localparam logic [16:0] ADDR_FAIL_LO = 17'h01000;
   localparam logic [16:0] ADDR_FAIL_HI = 17'h01004;
   localparam logic [16:0] ADDR_PROG_LO = 17'h01008;
   localparam logic [16:0] ADDR_PROG_HI = 17'h0100C;
   localparam logic [16:0] ADDR_EXP_BASE = 17'h01200;
   localparam logic [16:0] ADDR_ACT_BASE = 17'h01400;
   localparam logic [16:0] ADDR_IDEN_BASE = 17'h10000;
   localparam logic [16:0] ADDR_CTM_BASE = 17'h18000;
   // ***************************************************************
   // Field positions, sizes, beat size and unmapped read value
   // ***************************************************************
   localparam int STS_BUSY = 0;
   localparam int STS_ERROR = 1;
   localparam int STS_VFAIL = 2;
   localparam int CAP_MODE_BIT = 31;
   localparam int ADDR_BITS = 48;
   localparam int PROG_BITS = 57;
   localparam int SUBM_DWORDS = 16;
   localparam int DATA_BITS = 512;
   localparam int MEM_WORDS = 4096;
   localparam logic [PROG_BITS-1:0] BEAT_BYTES = 57'h40;
   localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
   // ***************************************************************
   // Commands
   // ***************************************************************
   typedef enum logic [2:0] {
      SSCS_IDENTIFY = 3'b000,
      SSCS_SHUTDOWN = 3'b001,
      SSCS_WRITE = 3'b010,
      SSCS_READ = 3'b011,
      SSCS_HEALTH = 3'b100,
      SSCS_RSVD5 = 3'b101,
      SSCS_FLUSH = 3'b110,
      SSCS_RSVD7 = 3'b111
   } sscs_cmd_code_t;
   // ***************************************************************
   // Carriers
   // ***************************************************************
   typedef struct packed {
      logic launch;
      sscs_cmd_code_t code;
      logic [ADDR_BITS-1:0] start_addr;
      logic [ADDR_BITS-1:0] xfer_len;
      logic [2:0] pattern;
      logic active;
   } sscs_cmd_t;
   typedef struct packed {
      logic done;
      logic error;
      logic [1:0][31:0] err_type;
      logic [ADDR_BITS-1:0] capacity;
      logic sector4k;
      logic beat;
      logic vfail;
      logic [PROG_BITS-1:0] vfail_addr;
      logic [DATA_BITS-1:0] exp_word;
      logic [DATA_BITS-1:0] act_word;
   } sscs_core_t;
   typedef struct packed {
      logic iden_wr;
      logic ctm_wr;
      logic ch;
      logic [10:0] word;
      logic [31:0] data;
   } sscs_memwr_t;
endpackage : sscs_pkg

// ### src/sscs_regs.sv
// Purpose: Command and status registers of a two-channel striped SSD controller.
// Assumes: Register port requests are single-cycle strobes; core events are one-cycle pulses.
// Notes: Read data returns one cycle after the read strobe with a valid pulse.
// Overview of operation
// - Command 000b launches identify on both channels.
// - Accepted command raises busy until finished.
// - Identify done clears busy, results in memory.
// - Failure sets error bit, per-channel type readable.
// - Capacity reported low/high, bit 31 sector mode.
// - Codes 010b write, 011b read transfer.
// - Read mismatch sets bit 2, transfer continues.
// - Running byte count readable, low and high.
// - Health log uses submission entries, code 100b.
// - Log data stored before busy clears.
// - Code 110b launches flush on both channels.
// - Code 001b launches shutdown, busy until done.
// - After shutdown, channels inactive, commands refused.
// - First failure captures address, expected, actual.
// - Codes 101b and 111b are reserved.
// - Address and length are 48-bit sector counts.
`timescale 1ns/1ps
`default_nettype none
module sscs_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [16:0] reg_addr,
   input wire logic [31:0] reg_wr_data,
   output logic [31:0] reg_rd_data,
   output logic reg_rd_valid,
   output sscs_pkg::sscs_cmd_t cmd,
   output logic [1:0][sscs_pkg::SUBM_DWORDS-1:0][31:0] subm_entry,
   input wire sscs_pkg::sscs_core_t core,
   input wire sscs_pkg::sscs_memwr_t memwr
);
   import sscs_pkg::*;

   typedef struct packed {
      sscs_cmd_t cmd;
      logic busy;
      logic error;
      logic vfail;
      logic captured;
      logic dead;
      logic [1:0][31:0] err_type;
      logic [ADDR_BITS-1:0] capacity;
      logic sector4k;
      logic [PROG_BITS-1:0] progress;
      logic [PROG_BITS-1:0] fail_addr;
      logic [DATA_BITS-1:0] exp_word;
      logic [DATA_BITS-1:0] act_word;
      logic [1:0][SUBM_DWORDS-1:0][31:0] subm;
      logic [31:0] rd_data;
      logic rd_valid;
   } sscs_state_t;

   sscs_state_t st;
   sscs_state_t next_st;
   logic [31:0] iden_mem [MEM_WORDS];
   logic [31:0] ctm_mem [MEM_WORDS];
   logic cmd_wr;
   logic accept;
   logic [11:0] mem_idx;
   logic [11:0] ctm_wr_idx;
   logic ctm_sw_wr;

   assign cmd_wr = reg_wr && (reg_addr == ADDR_COMMAND);
   // Reserved codes and writes during busy or after shutdown never reach the channels.
   assign accept = cmd_wr && !st.busy && !st.dead && (reg_wr_data[2:0] != SSCS_RSVD5) &&
      (reg_wr_data[2:0] != SSCS_RSVD7);
   assign mem_idx = reg_addr[13:2];
   assign ctm_sw_wr = reg_wr && (reg_addr[16:14] == ADDR_CTM_BASE[16:14]) && !memwr.ctm_wr;
   assign ctm_wr_idx = memwr.ctm_wr ? {memwr.ch, memwr.word} : mem_idx;

   // ***************************************************************
   // Identify and custom command memories
   // ***************************************************************
   // Core writes win over software writes to the custom memory in the same cycle.
   always_ff @(posedge clk) begin
      if (memwr.iden_wr) begin
         iden_mem[{memwr.ch, memwr.word}] <= memwr.data;
      end
      if (memwr.ctm_wr || ctm_sw_wr) begin
         ctm_mem[ctm_wr_idx] <= memwr.ctm_wr ? memwr.data : reg_wr_data;
      end
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_st = st;
      next_st.cmd.launch = 1'b0;
      next_st.rd_valid = 1'b0;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_START_LO: next_st.cmd.start_addr[31:0] = reg_wr_data;
            ADDR_START_HI: next_st.cmd.start_addr[47:32] = reg_wr_data[15:0];
            ADDR_LEN_LO: next_st.cmd.xfer_len[31:0] = reg_wr_data;
            ADDR_LEN_HI: next_st.cmd.xfer_len[47:32] = reg_wr_data[15:0];
            ADDR_PATTERN: next_st.cmd.pattern = reg_wr_data[2:0];
            default: begin
               if (reg_addr[16:7] == ADDR_SUBM_BASE[16:7]) begin
                  next_st.subm[reg_addr[6]][reg_addr[5:2]] = reg_wr_data;
               end
            end
         endcase
      end
      if (accept) begin
         next_st.cmd.launch = 1'b1;
         next_st.cmd.code = sscs_cmd_code_t'(reg_wr_data[2:0]);
         next_st.busy = 1'b1;
         next_st.error = 1'b0;
         next_st.vfail = 1'b0;
         if (reg_wr_data[2:0] == SSCS_WRITE || reg_wr_data[2:0] == SSCS_READ) begin
            next_st.progress = '0;
            next_st.captured = 1'b0;
         end
      end
      if (st.busy && core.beat) begin
         next_st.progress = st.progress + BEAT_BYTES;
      end
      // A mismatch only flags; the transfer keeps running.
      if (st.busy && core.vfail && st.cmd.code == SSCS_READ) begin
         next_st.vfail = 1'b1;
         if (!st.captured) begin
            next_st.captured = 1'b1;
            next_st.fail_addr = core.vfail_addr;
            next_st.exp_word = core.exp_word;
            next_st.act_word = core.act_word;
         end
      end
      if (st.busy && core.error) begin
         next_st.error = 1'b1;
         next_st.err_type = core.err_type;
      end
      if (st.busy && core.done) begin
         next_st.busy = 1'b0;
         if (st.cmd.code == SSCS_IDENTIFY) begin
            next_st.capacity = core.capacity;
            next_st.sector4k = core.sector4k;
         end
         if (st.cmd.code == SSCS_SHUTDOWN) begin
            next_st.dead = 1'b1;
            next_st.cmd.active = 1'b0;
         end
      end
      if (reg_rd) begin
         next_st.rd_valid = 1'b1;
         case (reg_addr)
            ADDR_START_LO: next_st.rd_data = st.cmd.start_addr[31:0];
            ADDR_START_HI: next_st.rd_data = {16'h0000, st.cmd.start_addr[47:32]};
            ADDR_LEN_LO: next_st.rd_data = st.cmd.xfer_len[31:0];
            ADDR_LEN_HI: next_st.rd_data = {16'h0000, st.cmd.xfer_len[47:32]};
            ADDR_PATTERN: next_st.rd_data = {29'h0000000, st.cmd.pattern};
            ADDR_STATUS: next_st.rd_data = {29'h0000000, st.vfail, st.error, st.busy};
            ADDR_CAP_LO: next_st.rd_data = st.capacity[31:0];
            ADDR_CAP_HI: next_st.rd_data = {st.sector4k, 15'h0000, st.capacity[47:32]};
            ADDR_ERR_CH0: next_st.rd_data = st.err_type[0];
            ADDR_ERR_CH1: next_st.rd_data = st.err_type[1];
            ADDR_FAIL_LO: next_st.rd_data = st.fail_addr[31:0];
            ADDR_FAIL_HI: next_st.rd_data = {7'h00, st.fail_addr[56:32]};
            ADDR_PROG_LO: next_st.rd_data = st.progress[31:0];
            ADDR_PROG_HI: next_st.rd_data = {7'h00, st.progress[56:32]};
            default: begin
               if (reg_addr[16:14] == ADDR_IDEN_BASE[16:14]) begin
                  next_st.rd_data = iden_mem[mem_idx];
               end else if (reg_addr[16:14] == ADDR_CTM_BASE[16:14]) begin
                  next_st.rd_data = ctm_mem[mem_idx];
               end else if (reg_addr[16:6] == ADDR_EXP_BASE[16:6]) begin
                  next_st.rd_data = st.exp_word[reg_addr[5:2]*32 +: 32];
               end else if (reg_addr[16:6] == ADDR_ACT_BASE[16:6]) begin
                  next_st.rd_data = st.act_word[reg_addr[5:2]*32 +: 32];
               end else if (reg_addr[16:7] == ADDR_SUBM_BASE[16:7]) begin
                  next_st.rd_data = st.subm[reg_addr[6]][reg_addr[5:2]];
               end else begin
                  next_st.rd_data = RD_UNMAPPED;
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // State register
   // ***************************************************************
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
         st.cmd.active <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rd_data = st.rd_data;
   assign reg_rd_valid = st.rd_valid;
   assign cmd = st.cmd;
   assign subm_entry = st.subm;

   // ***************************************************************
   // Assertions
   // ***************************************************************
   ident_launch_a: assert property (@(posedge clk) disable iff (rst)
      accept && reg_wr_data[2:0] == 3'b000 |=> cmd.launch && cmd.code == SSCS_IDENTIFY)
      else $error("identify write did not launch identify");
   busy_rise_a: assert property (@(posedge clk) disable iff (rst)
      accept |=> st.busy && !$past(st.busy))
      else $error("busy did not rise after accepted command");
   done_clear_a: assert property (@(posedge clk) disable iff (rst)
      st.busy && core.done |=> !st.busy ##1 (!st.busy || cmd.launch))
      else $error("busy not cleared on completion");
   error_set_a: assert property (@(posedge clk) disable iff (rst)
      st.busy && core.error |=> st.error && st.err_type == $past(core.err_type))
      else $error("error bit or type not captured");
   vfail_keep_a: assert property (@(posedge clk) disable iff (rst)
      st.busy && core.vfail && st.cmd.code == SSCS_READ && !core.done |=> st.vfail && st.busy)
      else $error("mismatch not flagged or transfer stopped");
   prog_step_a: assert property (@(posedge clk) disable iff (rst)
      st.busy && core.beat && !accept |=> st.progress == $past(st.progress) + BEAT_BYTES)
      else $error("progress count did not advance by one beat");
   shut_dead_a: assert property (@(posedge clk) disable iff (rst)
      st.dead |-> !cmd.launch && !cmd.active)
      else $error("command launched after shutdown");
   first_fail_a: assert property (@(posedge clk) disable iff (rst)
      st.captured && !accept |=> $stable(st.fail_addr) && $stable(st.act_word) &&
      $stable(st.exp_word))
      else $error("later failure overwrote first capture");
   reserved_a: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && reg_wr_data[2:0] inside {3'b101, 3'b111} |=> !cmd.launch)
      else $error("reserved code launched");
   busy_ignore_a: assert property (@(posedge clk) disable iff (rst)
      cmd_wr && st.busy |=> !cmd.launch && cmd.code == $past(cmd.code))
      else $error("command during busy disturbed operation");
endmodule : sscs_regs
`default_nettype wire

// ### testbench/tb.sv
// Purpose: Self-checking bench for the striped SSD command and status registers.
// Assumes: Core events and memory writes are one-cycle pulses driven by the bench.
// Notes: Random values come from a fixed seed, so every run is the same.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sscs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [16:0] reg_addr = 17'h00000;
   logic [31:0] reg_wr_data = 32'h00000000;
   logic [31:0] reg_rd_data;
   logic reg_rd_valid;
   sscs_cmd_t cmd;
   logic [1:0][SUBM_DWORDS-1:0][31:0] subm_entry;
   sscs_core_t core = '0;
   sscs_memwr_t memwr = '0;
   int n_fail = 0;
   int n_compared = 0;
   int seed = 6;
   always #10 clk = ~clk;
   sscs_regs dut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
      .cmd(cmd), .subm_entry(subm_entry), .core(core), .memwr(memwr));
   // ***************************************************************
   // Bus and event tasks
   // ***************************************************************
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task chk(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Status word as software reads it, built from the documented bit positions.
   function automatic logic [31:0] status_word(input logic busy, input logic err, input logic vf);
      logic [31:0] w;
      w = 32'h00000000;
      w[STS_BUSY] = busy;
      w[STS_ERROR] = err;
      w[STS_VFAIL] = vf;
      return w;
   endfunction : status_word
   // Running byte count after a number of data beats.
   function automatic logic [PROG_BITS-1:0] prog_bytes(input int beats);
      return BEAT_BYTES * PROG_BITS'(beats);
   endfunction : prog_bytes
   task wr(input logic [16:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   // The answer is looked at in the one cycle that the valid pulse stands.
   task rdchk(input logic [16:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rd_valid, 1'b1);
      chk(reg_rd_data, exp);
   endtask : rdchk
   task issue(input sscs_cmd_code_t code, input logic exp_launch);
      wr(ADDR_COMMAND, {29'h0, code});
      chk(cmd.launch, exp_launch);
   endtask : issue
   task ev(input sscs_core_t c);
      @(posedge clk);
      core <= c;
      @(posedge clk);
      core <= '0;
      #1;
   endtask : ev
   task mw(input sscs_memwr_t m);
      @(posedge clk);
      memwr <= m;
      @(posedge clk);
      memwr <= '0;
      #1;
   endtask : mw
   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      sscs_core_t c;
      sscs_core_t c2;
      sscs_memwr_t m;
      logic [31:0] d;
      logic [47:0] a48;
      logic [47:0] l48;
      logic [2:0] pat;
      logic [PROG_BITS-1:0] p;
      logic [31:0] sub [32];
      sscs_cmd_code_t seq [3];
      int nb;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk(cmd.active, 1'b1);
      rdchk(ADDR_STATUS, 32'h00000000);
      rdchk(17'h00200, RD_UNMAPPED);
      issue(SSCS_IDENTIFY, 1'b1);
      chk(cmd.code, SSCS_IDENTIFY);
      rdchk(ADDR_STATUS, 32'h00000001);
      issue(SSCS_READ, 1'b0);
      chk(cmd.code, SSCS_IDENTIFY);
      d = $random(seed);
      m = '0;
      m.iden_wr = 1'b1;
      m.ch = 1'b1;
      m.word = 11'h007;
      m.data = d;
      mw(m);
      c = '0;
      c.capacity = {16'($random(seed)), 32'($random(seed))};
      c.sector4k = 1'b1;
      c.done = 1'b1;
      ev(c);
      rdchk(ADDR_STATUS, 32'h00000000);
      rdchk(ADDR_IDEN_BASE + 17'h0201C, d);
      rdchk(ADDR_CAP_LO, c.capacity[31:0]);
      rdchk(ADDR_CAP_HI, {1'b1, 15'h0000, c.capacity[47:32]});
      $display("test identify done");
      a48 = {16'($random(seed)), 32'($random(seed))};
      l48 = {16'($random(seed)), 32'($random(seed))};
      pat = 3'($random(seed));
      wr(ADDR_START_LO, a48[31:0]);
      wr(ADDR_START_HI, {16'h0000, a48[47:32]});
      wr(ADDR_LEN_LO, l48[31:0]);
      wr(ADDR_LEN_HI, {16'h0000, l48[47:32]});
      wr(ADDR_PATTERN, {29'h0, pat});
      issue(SSCS_READ, 1'b1);
      chk(cmd.start_addr, a48);
      chk(cmd.xfer_len, l48);
      chk(cmd.pattern, pat);
      nb = 3 + {$random(seed)} % 5;
      c = '0;
      c.beat = 1'b1;
      repeat (nb) ev(c);
      p = prog_bytes(nb);
      rdchk(ADDR_PROG_LO, p[31:0]);
      rdchk(ADDR_PROG_HI, {7'h00, p[56:32]});
      c = '0;
      c.vfail = 1'b1;
      c.vfail_addr = {25'($random(seed)), 32'($random(seed))};
      for (int i = 0; i < 16; i++) begin
         c.exp_word[32*i+:32] = $random(seed);
         c.act_word[32*i+:32] = $random(seed);
      end
      ev(c);
      // A second failure must not overwrite the first capture.
      c2 = c;
      c2.vfail_addr = ~c.vfail_addr;
      c2.exp_word = ~c.exp_word;
      c2.act_word = ~c.act_word;
      ev(c2);
      rdchk(ADDR_STATUS, status_word(1'b1, 1'b0, 1'b1));
      rdchk(ADDR_FAIL_LO, c.vfail_addr[31:0]);
      rdchk(ADDR_FAIL_HI, {7'h00, c.vfail_addr[56:32]});
      for (int i = 0; i < 16; i++) begin
         rdchk(ADDR_EXP_BASE + 17'(4 * i), c.exp_word[32*i+:32]);
         rdchk(ADDR_ACT_BASE + 17'(4 * i), c.act_word[32*i+:32]);
      end
      c = '0;
      c.done = 1'b1;
      ev(c);
      rdchk(ADDR_STATUS, status_word(1'b0, 1'b0, 1'b1));
      $display("test read transfer done");
      for (int i = 0; i < 32; i++) begin
         sub[i] = $random(seed);
         wr(ADDR_SUBM_BASE + 17'(4 * i), sub[i]);
         chk(subm_entry[i/16][i%16], sub[i]);
      end
      issue(SSCS_HEALTH, 1'b1);
      rdchk(ADDR_STATUS, 32'h00000001);
      d = $random(seed);
      m = '0;
      m.ctm_wr = 1'b1;
      m.ch = 1'b1;
      m.word = 11'h005;
      m.data = d;
      mw(m);
      c = '0;
      c.error = 1'b1;
      c.err_type[0] = $random(seed);
      c.err_type[1] = $random(seed);
      ev(c);
      c.error = 1'b0;
      c.done = 1'b1;
      ev(c);
      rdchk(ADDR_STATUS, status_word(1'b0, 1'b1, 1'b0));
      rdchk(ADDR_ERR_CH0, c.err_type[0]);
      rdchk(ADDR_ERR_CH1, c.err_type[1]);
      rdchk(ADDR_CTM_BASE + 17'h02014, d);
      issue(SSCS_RSVD5, 1'b0);
      issue(SSCS_RSVD7, 1'b0);
      chk(cmd.code, SSCS_HEALTH);
      // Core events while idle must leave flags and the byte count alone.
      c = '0;
      c.vfail = 1'b1;
      c.beat = 1'b1;
      c.done = 1'b1;
      ev(c);
      rdchk(ADDR_STATUS, status_word(1'b0, 1'b1, 1'b0));
      rdchk(ADDR_PROG_LO, p[31:0]);
      $display("test health log done");
      seq[0] = SSCS_WRITE;
      seq[1] = SSCS_FLUSH;
      seq[2] = SSCS_SHUTDOWN;
      for (int i = 0; i < 3; i++) begin
         issue(seq[i], 1'b1);
         chk(cmd.code, seq[i]);
         // A mismatch outside a read transfer must not raise the flag.
         c = '0;
         c.vfail = 1'b1;
         ev(c);
         rdchk(ADDR_STATUS, status_word(1'b1, 1'b0, 1'b0));
         c = '0;
         c.done = 1'b1;
         ev(c);
         rdchk(ADDR_STATUS, 32'h00000000);
      end
      chk(cmd.active, 1'b0);
      issue(SSCS_IDENTIFY, 1'b0);
      rdchk(ADDR_STATUS, 32'h00000000);
      $display("test shutdown done");
      test_done();
   end
   // Whole run is well under 2000 cycles, so this only fires on a hang.
   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule : tb
`default_nettype wire
